// >>> tx_cell_irq_defines.svh
// Purpose: Register indices, field positions and reset values of the transmit cell interrupt tree.
// Assumes: Byte address on the register bus is four times the register index.
// Notes: Channel registers repeat every CHAN_STRIDE indices.
`ifndef TX_CELL_IRQ_DEFINES_SVH
`define TX_CELL_IRQ_DEFINES_SVH

`define NUM_CHAN          4
`define ADDR_W            20
`define IDX_W             18
`define IDX_BLK_STATUS    18'h00013
`define IDX_BLK_ENABLE    18'h00017
`define IDX_CHAN_IND      18'h00122
`define IDX_SRC_STATUS0   18'h01f0b
`define IDX_SRC_ENABLE0   18'h01f0f
`define IDX_SRC_CLEAR0    18'h01f0d
`define CHAN_STRIDE       18'h01000

`define BIT_EXTRACT       5
`define BIT_INSERT        4
`define BIT_EXT_OVF       3
`define BIT_INS_OVF       2
`define BIT_HEC_ERR       1
`define BIT_PAR_ERR       0
`define SRC_MASK          8'h3f
`define BLK_EN_MASK       8'hf9
`define BLK_TXCELL_BIT    3
`define IND_MASK          8'h0f

`define RST_BLK_ENABLE    8'h00
`define RST_SRC_ENABLE    8'h00
`define RST_SRC_STATUS    8'h00

`endif

// >>> tx_cell_irq_pkg.sv
// Purpose: Types shared by the transmit cell interrupt tree.
// Assumes: One set of event strobes per channel.
// Notes: Event fields are single-cycle pulses or levels as named.
package tx_cell_irq_pkg;

  typedef struct packed {
    logic cell_extracted;
    logic cell_inserted;
    logic ext_buf_full;
    logic ext_cell_load;
    logic ins_buf_ovf;
    logic hec_err;
    logic par_err;
  } chan_events_t;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;

endpackage : tx_cell_irq_pkg

// >>> tx_cell_irq.sv
// Purpose: Three-level interrupt tree of the transmit cell processor with an AXI4-Lite slave.
// Assumes: Event inputs are synchronous to clock_in; one read and one write outstanding at most.
// Notes: Source status clears on read and through the clear register; a new event always wins.
//
// Notes on behaviour
// - Channel indicator bits 3..0 flag pending channels 3..0; bits 7..4 read zero.
// - Source status: extraction, insertion, two overflows, HEC error, parity error in bits 5..0.
// - Insertion flag sets whenever a cell moves from insertion buffer into transmit path.
// - Loading a copied cell into a full extraction buffer raises the overflow flag.
// - Block-level enable bit 3 gates any interrupt from this processor.
// - With source enable bit 3 and block enable bit 3 set, each extraction overflow interrupts the processor.
// - Source enable bits 5..0 read/write, each enabling same status bit; 7..6 read zero.
// - Block enable bits 7..3 and 0 read/write; bits 2..1 read-only zero.
// - Block status bit 3 is set while this processor has a pending interrupt.
`timescale 1ns/1ps
`include "tx_cell_irq_defines.svh"

module tx_cell_irq (
  // Clock, reset and enable
  input  wire logic                          clock_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          ce_in,
  // Per-channel events from the cell datapath
  input  wire tx_cell_irq_pkg::chan_events_t events_in [`NUM_CHAN],
  // AXI4-Lite write address and data
  input  wire logic [`ADDR_W-1:0]            awaddr_in,
  input  wire logic                          awvalid_in,
  output logic                               awready_out,
  input  wire logic [31:0]                   wdata_in,
  input  wire logic [3:0]                    wstrb_in,
  input  wire logic                          wvalid_in,
  output logic                               wready_out,
  // AXI4-Lite write response
  output logic [1:0]                         bresp_out,
  output logic                               bvalid_out,
  input  wire logic                          bready_in,
  // AXI4-Lite read
  input  wire logic [`ADDR_W-1:0]            araddr_in,
  input  wire logic                          arvalid_in,
  output logic                               arready_out,
  output logic [31:0]                        rdata_out,
  output logic [1:0]                         rresp_out,
  output logic                               rvalid_out,
  input  wire logic                          rready_in,
  // Interrupt
  output logic                               irq_out
);
  import tx_cell_irq_pkg::*;

  logic [7:0]               block_enable;
  logic [7:0]               src_status  [`NUM_CHAN];
  logic [7:0]               src_enable  [`NUM_CHAN];
  logic [`NUM_CHAN-1:0]     chan_pending;
  logic                     tx_cell_pending;
  logic [`ADDR_W-1:0]       aw_addr;
  logic [31:0]              w_data;
  logic [3:0]               w_strb;
  logic                     aw_held;
  logic                     w_held;
  logic                     aw_hs;
  logic                     w_hs;
  logic                     ar_hs;
  logic                     wr_fire;
  logic [`IDX_W-1:0]        wr_idx;
  logic [`IDX_W-1:0]        rd_idx;
  logic [7:0]               wr_byte;
  logic                     wr_lane0;
  logic [7:0]               next_rdata;
  logic                     rd_mapped;
  logic                     wr_mapped;
  logic [`NUM_CHAN-1:0]     rd_status_hit;
  logic [`NUM_CHAN-1:0]     wr_enable_hit;
  logic [`NUM_CHAN-1:0]     wr_clear_hit;
  logic [`NUM_CHAN-1:0]     wr_status_hit;
  logic [`NUM_CHAN-1:0]     rd_chan_hit;
  logic [7:0]               rd_chan_data [`NUM_CHAN];

  // Handshakes stall completely while the clock enable is low.
  assign awready_out = ce_in & ~aw_held & ~bvalid_out;
  assign wready_out  = ce_in & ~w_held & ~bvalid_out;
  assign arready_out = ce_in & ~rvalid_out;
  assign aw_hs       = awvalid_in & awready_out;
  assign w_hs        = wvalid_in & wready_out;
  assign ar_hs       = arvalid_in & arready_out;
  assign wr_fire     = ce_in & ~bvalid_out & (aw_held | aw_hs) & (w_held | w_hs);

  assign wr_idx   = aw_held ? aw_addr[`ADDR_W-1:2] : awaddr_in[`ADDR_W-1:2];
  assign wr_byte  = w_held ? w_data[7:0] : wdata_in[7:0];
  assign wr_lane0 = w_held ? w_strb[0] : wstrb_in[0];
  assign rd_idx   = araddr_in[`ADDR_W-1:2];

  // Address and data are taken in either order and held until both are present.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else if (ce_in) begin
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end else begin
        if (aw_hs) begin
          aw_held <= 1'b1;
          aw_addr <= awaddr_in;
        end
        if (w_hs) begin
          w_held <= 1'b1;
          w_data <= wdata_in;
          w_strb <= wstrb_in;
        end
      end
    end
  end

  // Write response one cycle after both halves are in.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      bvalid_out <= 1'b0;
      bresp_out  <= RESP_OKAY;
    end else if (ce_in) begin
      if (wr_fire) begin
        bvalid_out <= 1'b1;
        bresp_out  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_in) begin
        bvalid_out <= 1'b0;
      end
    end
  end

  // A write to a read-only register is accepted and dropped, so a blind write-back never raises a bus error.
  assign wr_mapped = (wr_idx == `IDX_BLK_ENABLE) | (wr_idx == `IDX_BLK_STATUS) | (wr_idx == `IDX_CHAN_IND)
                   | (|wr_enable_hit) | (|wr_clear_hit) | (|wr_status_hit);

  // Block enable: only the writable bits store.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      block_enable <= `RST_BLK_ENABLE;
    end else if (ce_in && wr_fire && wr_lane0 && wr_idx == `IDX_BLK_ENABLE) begin
      block_enable <= wr_byte & `BLK_EN_MASK;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CHAN; ch++) begin : g_chan
      logic [7:0] set_bits;
      logic [7:0] clr_bits;

      assign rd_status_hit[ch] = ar_hs && rd_idx == `IDX_W'(`IDX_SRC_STATUS0 + ch * `CHAN_STRIDE);
      assign wr_enable_hit[ch] = wr_idx == `IDX_W'(`IDX_SRC_ENABLE0 + ch * `CHAN_STRIDE);
      assign wr_clear_hit[ch]  = wr_idx == `IDX_W'(`IDX_SRC_CLEAR0 + ch * `CHAN_STRIDE);
      assign wr_status_hit[ch] = wr_idx == `IDX_W'(`IDX_SRC_STATUS0 + ch * `CHAN_STRIDE);
      assign rd_chan_hit[ch]   = rd_idx == `IDX_W'(`IDX_SRC_STATUS0 + ch * `CHAN_STRIDE)
                               | rd_idx == `IDX_W'(`IDX_SRC_ENABLE0 + ch * `CHAN_STRIDE);
      assign rd_chan_data[ch]  = (rd_idx == `IDX_W'(`IDX_SRC_STATUS0 + ch * `CHAN_STRIDE))
                               ? src_status[ch] : src_enable[ch];

      always_comb begin
        set_bits                = 8'h00;
        set_bits[`BIT_EXTRACT]  = events_in[ch].cell_extracted;
        set_bits[`BIT_INSERT]   = events_in[ch].cell_inserted;
        set_bits[`BIT_EXT_OVF]  = events_in[ch].ext_buf_full & events_in[ch].ext_cell_load;
        set_bits[`BIT_INS_OVF]  = events_in[ch].ins_buf_ovf;
        set_bits[`BIT_HEC_ERR]  = events_in[ch].hec_err;
        set_bits[`BIT_PAR_ERR]  = events_in[ch].par_err;
      end

      // Clear on read or by write; a set in the same cycle survives.
      assign clr_bits = (rd_status_hit[ch] ? `SRC_MASK : 8'h00)
                      | ((wr_fire && wr_lane0 && wr_clear_hit[ch]) ? (wr_byte & `SRC_MASK) : 8'h00);

      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          src_status[ch] <= `RST_SRC_STATUS;
        end else if (ce_in) begin
          src_status[ch] <= ((src_status[ch] & ~clr_bits) | set_bits) & `SRC_MASK;
        end
      end

      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          src_enable[ch] <= `RST_SRC_ENABLE;
        end else if (ce_in && wr_fire && wr_lane0 && wr_enable_hit[ch]) begin
          src_enable[ch] <= wr_byte & `SRC_MASK;
        end
      end

      assign chan_pending[ch] = |(src_status[ch] & src_enable[ch]);

      ovf_sets_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ce_in && events_in[ch].ext_buf_full && events_in[ch].ext_cell_load |=> src_status[ch][`BIT_EXT_OVF])
        else $error("Extraction overflow flag not set.");
      ins_sets_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ce_in && events_in[ch].cell_inserted |=> src_status[ch][`BIT_INSERT])
        else $error("Insertion flag not set.");
      read_clears_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        rd_status_hit[ch] && set_bits == 8'h00 |=> src_status[ch] == 8'h00 && rvalid_out)
        else $error("Status not cleared by read.");
      read_keeps_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        rd_status_hit[ch] && events_in[ch].par_err |=> src_status[ch][`BIT_PAR_ERR])
        else $error("Event lost during clearing read.");
      enable_store_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wr_fire && wr_lane0 && wr_enable_hit[ch] |=> src_enable[ch] == ($past(wr_byte) & 8'h3f))
        else $error("Source enable write wrong.");

      unused_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        src_status[ch][7:6] == 2'b00 && src_enable[ch][7:6] == 2'b00)
        else $error("Unused source bits set.");
      clear_write_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wr_fire && wr_lane0 && wr_clear_hit[ch] && wr_byte[`BIT_EXT_OVF] && !set_bits[`BIT_EXT_OVF]
        |=> !src_status[ch][`BIT_EXT_OVF])
        else $error("Clear register write did not clear.");
      // Events arriving while the clock enable is low are dropped, not queued.
      chan_freeze_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !ce_in |=> $stable(src_status[ch]) && $stable(src_enable[ch]))
        else $error("Channel state moved with clock enable low.");
    end
  endgenerate

  assign tx_cell_pending = |chan_pending;
  // Gating at the output keeps flags visible to polling software even when masked.
  assign irq_out = block_enable[`BLK_TXCELL_BIT] & tx_cell_pending;

  // Read mux; the status value returned is the one before the clear.
  always_comb begin
    next_rdata = 8'h00;
    rd_mapped  = 1'b1;
    if (rd_idx == `IDX_BLK_ENABLE) begin
      next_rdata = block_enable;
    end else if (rd_idx == `IDX_BLK_STATUS) begin
      next_rdata = 8'h00;
      next_rdata[`BLK_TXCELL_BIT] = tx_cell_pending;
    end else if (rd_idx == `IDX_CHAN_IND) begin
      next_rdata = {4'h0, chan_pending};
    end else begin
      rd_mapped = |rd_chan_hit;
      for (int c = 0; c < `NUM_CHAN; c++) begin
        if (rd_chan_hit[c]) begin
          next_rdata = rd_chan_data[c];
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rvalid_out <= 1'b0;
      rdata_out  <= 32'h0000_0000;
      rresp_out  <= RESP_OKAY;
    end else if (ce_in) begin
      if (ar_hs) begin
        rvalid_out <= 1'b1;
        rdata_out  <= {24'h00_0000, next_rdata};
        rresp_out  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_in) begin
        rvalid_out <= 1'b0;
      end
    end
  end

  irq_gate_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    irq_out |-> block_enable[3] && tx_cell_pending)
    else $error("Interrupt without block enable.");
  ovf_irq_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    block_enable[3] && src_enable[0][3] && src_status[0][3] |-> irq_out)
    else $error("Overflow did not interrupt.");
  irq_drop_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(tx_cell_pending) |-> !irq_out)
    else $error("Interrupt stayed after flags cleared.");
  ind_read_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ar_hs && rd_idx == `IDX_CHAN_IND |=> rvalid_out && rdata_out == {28'h000_0000, $past(chan_pending)})
    else $error("Channel indicator read wrong.");
  blk_stat_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ar_hs && rd_idx == `IDX_BLK_STATUS |=> rdata_out == {28'h000_0000, $past(tx_cell_pending), 3'h0})
    else $error("Block status read wrong.");
  blk_ro_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wr_fire && wr_lane0 && wr_idx == `IDX_BLK_ENABLE |=> block_enable == ($past(wr_byte) & 8'hf9))
    else $error("Block enable write wrong.");
  bresp_time_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wr_fire |=> bvalid_out)
    else $error("Write response late.");

  blk_unused_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    block_enable[2:1] == 2'b00)
    else $error("Read-only block enable bits set.");
  blk_freeze_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !ce_in |=> $stable(block_enable) && $stable(rvalid_out) && $stable(bvalid_out))
    else $error("Block state moved with clock enable low.");

  // The master may hold off its ready for any number of cycles, so answers must stand.
  rdata_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out) && $stable(rresp_out))
    else $error("Read answer changed before it was taken.");
  bresp_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("Write answer changed before it was taken.");

  // Only one write and one read are under way at a time.
  wr_refuse_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    bvalid_out |-> !awready_out && !wready_out)
    else $error("Write accepted while a response is pending.");
  rd_refuse_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rvalid_out |-> !arready_out)
    else $error("Read accepted while read data is pending.");

endmodule : tx_cell_irq

// >>> cpu_model.sv
// Purpose: Bus master model of the processor that services the interrupt tree.
// Assumes: One AXI4-Lite slave; each task starts one edge after it is called.
// Notes: A wait that runs past its bound sets hung for the bench to report.
`timescale 1ns/1ps
`include "tx_cell_irq_defines.svh"

module cpu_model (
  // Clock
  input  wire logic               clock_in,
  // Write channels
  output logic [`ADDR_W-1:0]      awaddr_out,
  output logic                    awvalid_out,
  input  wire logic               awready_in,
  output logic [31:0]             wdata_out,
  output logic [3:0]              wstrb_out,
  output logic                    wvalid_out,
  input  wire logic               wready_in,
  input  wire logic [1:0]         bresp_in,
  input  wire logic               bvalid_in,
  output logic                    bready_out,
  // Read channels
  output logic [`ADDR_W-1:0]      araddr_out,
  output logic                    arvalid_out,
  input  wire logic               arready_in,
  input  wire logic [31:0]        rdata_in,
  input  wire logic [1:0]         rresp_in,
  input  wire logic               rvalid_in,
  output logic                    rready_out
);
  logic hung = 1'b0;

  initial begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
  end

  // Released payloads are inverted so that a slave sampling late sees garbage.
  // Handshakes are judged mid-cycle, where they equal what the slave samples at the next rising edge;
  // reading them right at the edge would race the slave's own register updates.
  task automatic wr(input logic [17:0] idx, input logic [7:0] d, output logic [1:0] resp);
    int   n;
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    n    = 0;
    b_ok = 1'b0;
    resp = 2'h0;
    @(posedge clock_in);
    awaddr_out  <= {idx, 2'b00};
    wdata_out   <= {24'h000000, d};
    wstrb_out   <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out  <= 1'b1;
    bready_out  <= 1'b1;
    do begin
      @(negedge clock_in);
      aw_ok = awvalid_out && awready_in;
      w_ok  = wvalid_out && wready_in;
      b_ok  = bvalid_in;
      resp  = bresp_in;
      @(posedge clock_in);
      n++;
      if (aw_ok) begin
        awvalid_out <= 1'b0;
        awaddr_out  <= ~awaddr_out;
      end
      if (w_ok) begin
        wvalid_out <= 1'b0;
        wdata_out  <= ~wdata_out;
      end
    end while (!b_ok && n < 100);
    bready_out <= 1'b0;
    if (!b_ok) hung = 1'b1;
  endtask : wr

  task automatic rd(input logic [17:0] idx, output logic [31:0] data, output logic [1:0] resp);
    int   n;
    logic ar_ok;
    logic r_ok;
    n    = 0;
    r_ok = 1'b0;
    data = 32'h0000_0000;
    resp = 2'h0;
    @(posedge clock_in);
    araddr_out  <= {idx, 2'b00};
    arvalid_out <= 1'b1;
    rready_out  <= 1'b1;
    do begin
      @(negedge clock_in);
      ar_ok = arvalid_out && arready_in;
      r_ok  = rvalid_in;
      data  = rdata_in;
      resp  = rresp_in;
      @(posedge clock_in);
      n++;
      if (ar_ok) begin
        arvalid_out <= 1'b0;
        araddr_out  <= ~araddr_out;
      end
    end while (!r_ok && n < 100);
    rready_out <= 1'b0;
    if (!r_ok) hung = 1'b1;
  endtask : rd

  // Service order: block status, channel indicator, then the lowest flagged channel.
  task automatic isr(output logic [31:0] blk, output logic [31:0] ind, output logic [31:0] src);
    logic [1:0] r;
    int         c;
    rd(`IDX_BLK_STATUS, blk, r);
    rd(`IDX_CHAN_IND, ind, r);
    c = 0;
    while (c < 3 && !ind[c]) c++;
    rd(`IDX_SRC_STATUS0 + 18'(c) * `CHAN_STRIDE, src, r);
  endtask : isr
endmodule : cpu_model

// >>> tb_atm_tx_cell_interrupt_tree.sv
// Purpose: Self-checking bench of the transmit cell interrupt tree.
// Assumes: The clock enable stays high except during the clock enable test; events are driven one channel at a time.
// Notes: Expected values come from the register masks and bit positions.
`timescale 1ns/1ps
`include "tx_cell_irq_defines.svh"

module tb_atm_tx_cell_interrupt_tree;
  import tx_cell_irq_pkg::*;
  logic               clock_in = 1'b0;
  logic               sys_rst_in = 1'b1;
  logic               ce_in = 1'b1;
  chan_events_t       events_in [`NUM_CHAN];
  chan_events_t       e;
  logic [`ADDR_W-1:0] awaddr, araddr;
  logic [31:0]        wdata, rdata, d1, d2, d3;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic               awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
  int                 n_fail = 0;
  int                 comparisons = 0;

  always #2.5 clock_in = ~clock_in;

  tx_cell_irq u_tx_cell_irq (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .events_in(events_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb),
    .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready), .irq_out(irq));
  cpu_model u_cpu_model (.clock_in(clock_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
    .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
    .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
    .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
    if (u_cpu_model.hung) begin
      n_fail++;
      finish_test();
    end
  endtask : chk

  task automatic rchk(input logic [17:0] idx, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    u_cpu_model.rd(idx, d, r);
    chk($sformatf("data at index %h", idx), {24'h000000, exp}, d);
    chk($sformatf("read resp at index %h", idx), {30'h0, er}, {30'h0, r});
  endtask : rchk

  task automatic wchk(input logic [17:0] idx, input logic [7:0] v, input logic [1:0] er);
    logic [1:0] r;
    u_cpu_model.wr(idx, v, r);
    chk($sformatf("write resp at index %h", idx), {30'h0, er}, {30'h0, r});
  endtask : wchk

  // Holds the event for one cycle, then leaves time for the flag to land.
  task automatic pulse(input int c, input chan_events_t ev_v);
    @(posedge clock_in);
    events_in[c] <= ev_v;
    @(posedge clock_in);
    events_in[c] <= '0;
    repeat (2) @(posedge clock_in);
    #1;
  endtask : pulse

  function automatic chan_events_t ev(input int b);
    chan_events_t x;
    x = '0;
    case (b)
      5: x.cell_extracted = 1'b1;
      4: x.cell_inserted = 1'b1;
      3: {x.ext_buf_full, x.ext_cell_load} = 2'h3;
      2: x.ins_buf_ovf = 1'b1;
      1: x.hec_err = 1'b1;
      default: x.par_err = 1'b1;
    endcase
    return x;
  endfunction : ev

  function automatic logic [17:0] cidx(input logic [17:0] base, input int c);
    return base + 18'(c) * `CHAN_STRIDE;
  endfunction : cidx

  initial begin
    foreach (events_in[i]) events_in[i] = '0;
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rchk(`IDX_BLK_ENABLE, 8'h00, RESP_OKAY);
    wchk(`IDX_BLK_ENABLE, 8'hff, RESP_OKAY);
    rchk(`IDX_BLK_ENABLE, `BLK_EN_MASK, RESP_OKAY);
    for (int c = 0; c < `NUM_CHAN; c++) begin
      rchk(cidx(`IDX_SRC_ENABLE0, c), 8'h00, RESP_OKAY);
      wchk(cidx(`IDX_SRC_ENABLE0, c), 8'hff, RESP_OKAY);
      rchk(cidx(`IDX_SRC_ENABLE0, c), `SRC_MASK, RESP_OKAY);
    end
    $display("Test register masks done");
    for (int c = 0; c < `NUM_CHAN; c++) begin
      for (int b = 0; b < 6; b++) begin
        pulse(c, ev(b));
        chk("irq raised", 32'h1, {31'h0, irq});
        u_cpu_model.isr(d1, d2, d3);
        chk("block status", 32'h1 << `BLK_TXCELL_BIT, d1);
        chk("indicator", 32'h1 << c, d2);
        chk("source status", 32'h1 << b, d3);
        #1;
        chk("irq dropped", 32'h0, {31'h0, irq});
        rchk(cidx(`IDX_SRC_STATUS0, c), 8'h00, RESP_OKAY);
      end
    end
    $display("Test each source done");
    e = ev(3);
    e.ext_buf_full = 1'b0;
    pulse(0, e);
    rchk(`IDX_SRC_STATUS0, 8'h00, RESP_OKAY);
    wchk(`IDX_BLK_ENABLE, 8'h00, RESP_OKAY);
    pulse(1, ev(3));
    chk("irq gated", 32'h0, {31'h0, irq});
    rchk(`IDX_CHAN_IND, 8'h02, RESP_OKAY);
    wchk(`IDX_BLK_ENABLE, 8'h08, RESP_OKAY);
    #1;
    chk("irq ungated", 32'h1, {31'h0, irq});
    wchk(cidx(`IDX_SRC_CLEAR0, 1), 8'h08, RESP_OKAY);
    #1;
    chk("irq after clear", 32'h0, {31'h0, irq});
    rchk(cidx(`IDX_SRC_CLEAR0, 1), 8'h00, RESP_SLVERR);
    wchk(cidx(`IDX_SRC_ENABLE0, 2), 8'h37, RESP_OKAY);
    pulse(2, ev(3));
    chk("irq source off", 32'h0, {31'h0, irq});
    rchk(cidx(`IDX_SRC_STATUS0, 2), 8'h08, RESP_OKAY);
    wchk(cidx(`IDX_SRC_STATUS0, 3), 8'hff, RESP_OKAY);
    rchk(cidx(`IDX_SRC_STATUS0, 3), 8'h00, RESP_OKAY);
    rchk(18'h00100, 8'h00, RESP_SLVERR);
    wchk(18'h00100, 8'hff, RESP_SLVERR);
    $display("Test gating and access done");
    @(posedge clock_in);
    ce_in <= 1'b0;
    pulse(3, ev(5));
    @(posedge clock_in);
    ce_in <= 1'b1;
    rchk(cidx(`IDX_SRC_STATUS0, 3), 8'h00, RESP_OKAY);
    $display("Test clock enable done");
    // The event lands on the same edge that clears the flag by reading.
    fork
      rchk(`IDX_SRC_STATUS0, 8'h00, RESP_OKAY);
      begin
        @(posedge clock_in);
        events_in[0] <= ev(4);
        @(posedge clock_in);
        events_in[0] <= '0;
      end
    join
    rchk(`IDX_SRC_STATUS0, 8'h10, RESP_OKAY);
    // Software refills the insertion buffer; sending that cell raises the insertion flag again.
    pulse(0, ev(`BIT_INSERT));
    rchk(`IDX_SRC_STATUS0, 8'h10, RESP_OKAY);
    $display("Test set during read done");
    finish_test();
  end
endmodule : tb_atm_tx_cell_interrupt_tree
